/* src/hdcf_map.vh */
// constants shared by the dual-clock buffer control block
`ifndef HDCF_MAP_VH
`define HDCF_MAP_VH

// storage geometry
`define HDCF_DATA_W 9
`define HDCF_ADDR_W 16
`define HDCF_PTR_W 17
`define HDCF_DEPTH 17'h10000
`define HDCF_HALF 17'h08000

// offset register width and defaults chosen by the load pin at full clear
`define HDCF_OFF_W 16
`define HDCF_OFF_DEF_PAR 16'h007F
`define HDCF_OFF_DEF_SER 16'h03FF

// offset byte slots for parallel load and read-back
`define HDCF_SLOT_W 2
`define HDCF_SLOT_E_LSB 2'h0
`define HDCF_SLOT_E_MSB 2'h1
`define HDCF_SLOT_F_LSB 2'h2
`define HDCF_SLOT_F_MSB 2'h3

// replay setup length in read-clock edges
`define HDCF_REPLAY_EDGES 2'h2

// pin synchroniser vector layout
`define HDCF_PIN_W 19
`define HDCF_PIN_WCLK 0
`define HDCF_PIN_RCLK 1
`define HDCF_PIN_WEN 2
`define HDCF_PIN_REN 3
`define HDCF_PIN_RPL 4
`define HDCF_PIN_LD 5
`define HDCF_PIN_FSI 6
`define HDCF_PIN_SEN 7
`define HDCF_PIN_FCLR 8
`define HDCF_PIN_PCLR 9
`define HDCF_PIN_DLSB 10
`define HDCF_PIN_DMSB 18
// reset level of the synchronised pins: enables and clears inactive high
`define HDCF_PIN_RST 19'h003BC

`endif

/* src/hdcf_pin_sync.v */
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module hdcf_pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_pin,
  output reg [WIDTH-1:0] o_level,
  output reg [WIDTH-1:0] o_rise
);

  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  reg [WIDTH-1:0] level_next;
  integer k;

  ////////////////////////////////////////////////////////////////////////
  // a change counts only once stages two and three agree
  always @* begin
    level_next = o_level;
    for (k = 0; k < WIDTH; k = k + 1) begin
      if (s2_reg[k] == s3_reg[k]) begin
        level_next[k] = s3_reg[k];
      end
    end
  end

  // stage one feeds stage two only
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      o_level <= RST_VAL;
      o_rise <= {WIDTH{1'b0}};
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      o_level <= level_next;
      o_rise <= level_next & ~o_level;
    end
  end

endmodule

/* src/hdcf_top.v */
// control of a deep 9-bit dual-clock first-in first-out buffer
//
// Summary of operation
// - full clear resets pointers and partial flags
// - full clear picks standard or fall-through mode
// - load low: offsets 127, parallel loading only
// - load high: offsets 1023, serial loading only
// - offsets always readable back in parallel
// - full clear zeroes output, acts asynchronously
// - partial clear resets pointers, flags, keeps mode
// - partial clear keeps offsets and method, zeroes output
// - replay sampled low on read edge, enables idle
// - standard replay: empty low until the two setup read edges pass
// - fall-through replay: first word shows without read
// - standard mode outputs only requested words
// - fall-through first word after three read edges
// - select pin becomes serial offset input afterwards
// - idle write clock freezes write-side flags
// - enabled write stores word when not full
// - standard full flag frees two write edges later
// - fall-through input-space frees two write edges later
// - write enable ignored while full
// - idle read clock freezes read-side flags
// - data words are nine bits wide
// - standard mode: enabled read loads output, else output holds
// - empty flag rises two read edges after write
// - output-valid rises on read past last word
`timescale 1ns/1ps
`include "hdcf_map.vh"
module hdcf_top (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_full_clear_n,
  input wire i_partial_clear_n,
  input wire i_wr_clk,
  input wire i_wr_en_n,
  input wire [`HDCF_DATA_W-1:0] i_wr_data,
  input wire i_rd_clk,
  input wire i_rd_en_n,
  input wire i_replay_n,
  input wire i_offset_load_n,
  input wire i_serial_en_n,
  input wire i_fallthrough_select_serial_in,
  output reg [`HDCF_DATA_W-1:0] o_rd_data,
  output wire o_empty_flag_n,
  output wire o_full_flag_n,
  output reg o_almost_empty_n,
  output reg o_almost_full_n,
  output reg o_half_full_n,
  output reg o_fallthrough_mode,
  output reg o_serial_method
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation: link clocks are sampled, their edges are enables
  wire [`HDCF_PIN_W-1:0] pin_raw;
  wire [`HDCF_PIN_W-1:0] pin_lvl;
  wire [`HDCF_PIN_W-1:0] pin_rise;

  // data bits share the filter; they settle well before the write clock
  // edge is seen, so a word is never taken while half changed
  assign pin_raw = {i_wr_data, i_partial_clear_n, i_full_clear_n,
                    i_serial_en_n, i_fallthrough_select_serial_in,
                    i_offset_load_n, i_replay_n, i_rd_en_n, i_wr_en_n,
                    i_rd_clk, i_wr_clk};

  hdcf_pin_sync #(
    .WIDTH(`HDCF_PIN_W),
    .RST_VAL(`HDCF_PIN_RST)
  ) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(pin_raw),
    .o_level(pin_lvl),
    .o_rise(pin_rise)
  );

  wire w_edge = pin_rise[`HDCF_PIN_WCLK];
  wire r_edge = pin_rise[`HDCF_PIN_RCLK];
  wire wen_n = pin_lvl[`HDCF_PIN_WEN];
  wire ren_n = pin_lvl[`HDCF_PIN_REN];
  wire rpl_n = pin_lvl[`HDCF_PIN_RPL];
  wire ld_n = pin_lvl[`HDCF_PIN_LD];
  wire fsi = pin_lvl[`HDCF_PIN_FSI];
  wire sen_n = pin_lvl[`HDCF_PIN_SEN];
  wire fclr_act = ~pin_lvl[`HDCF_PIN_FCLR];
  wire [`HDCF_DATA_W-1:0] wdata = pin_lvl[`HDCF_PIN_DMSB:`HDCF_PIN_DLSB];

  // both clear pins act on the datapath without waiting for a clock
  // hazard: their release is not aligned to the core clock; link traffic
  // reaches the flops only through the pin synchroniser, so the first
  // edge after a release always lands several core cycles later
  wire clr_any = i_rst | ~i_full_clear_n | ~i_partial_clear_n;

  ////////////////////////////////////////////////////////////////////////
  // storage and pointers
  reg [`HDCF_DATA_W-1:0] mem [0:`HDCF_DEPTH-1];
  reg [`HDCF_PTR_W-1:0] wptr_reg;
  reg [`HDCF_PTR_W-1:0] wgray_reg;
  reg [`HDCF_PTR_W-1:0] rptr_reg;
  reg [`HDCF_PTR_W-1:0] rgray_reg;
  reg [`HDCF_PTR_W-1:0] wq1_reg;
  reg [`HDCF_PTR_W-1:0] wq2_reg;
  reg [`HDCF_PTR_W-1:0] rq1_reg;
  reg [`HDCF_PTR_W-1:0] rq2_reg;
  reg out_valid_reg;
  reg [1:0] replay_cnt_reg;
  reg [`HDCF_OFF_W-1:0] empty_off_reg;
  reg [`HDCF_OFF_W-1:0] full_off_reg;
  reg [`HDCF_SLOT_W-1:0] wslot_reg;
  reg [`HDCF_SLOT_W-1:0] rslot_reg;

  // pointers cross domains in gray code: one bit moves per step, so a
  // sampled copy is either the old or the new pointer, never a mixture
  function [`HDCF_PTR_W-1:0] gray2bin;
    input [`HDCF_PTR_W-1:0] g;
    integer i;
    begin
      gray2bin[`HDCF_PTR_W-1] = g[`HDCF_PTR_W-1];
      for (i = `HDCF_PTR_W - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  function [`HDCF_PTR_W-1:0] bin2gray;
    input [`HDCF_PTR_W-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // derived occupancy, each side sees only its synchronised copy
  wire [`HDCF_PTR_W-1:0] wq2_bin = gray2bin(wq2_reg);
  wire [`HDCF_PTR_W-1:0] rq2_bin = gray2bin(rq2_reg);
  wire [`HDCF_PTR_W-1:0] cnt_w = wptr_reg - rq2_bin;
  wire [`HDCF_PTR_W-1:0] cnt_r = wq2_bin - rptr_reg;
  wire full = (cnt_w == `HDCF_DEPTH);
  wire mem_has_data = (wq2_bin != rptr_reg);
  wire replay_busy = (replay_cnt_reg != 2'h0);
  wire [`HDCF_PTR_W-1:0] wptr_inc = wptr_reg + 17'h00001;
  wire [`HDCF_PTR_W-1:0] rptr_inc = rptr_reg + 17'h00001;
  wire [`HDCF_ADDR_W-1:0] waddr = wptr_reg[`HDCF_ADDR_W-1:0];
  wire [`HDCF_ADDR_W-1:0] raddr = rptr_reg[`HDCF_ADDR_W-1:0];

  // accepted write to the array, ignored while full or loading offsets
  wire wr_go = w_edge & ~wen_n & ld_n & ~full;
  // offset loads, each only under the method chosen at full clear
  wire par_load = w_edge & ~wen_n & ~ld_n & ~o_serial_method;
  wire ser_load = w_edge & ~sen_n & ~ld_n & o_serial_method;
  // parallel read-back works under either method
  wire off_read = r_edge & ~ren_n & ~ld_n;
  wire rpl_start = r_edge & ~rpl_n & ~replay_busy;

  // standard read: only on request, never while empty
  wire std_rd = r_edge & ~ren_n & ld_n & mem_has_data & ~replay_busy
                & ~rpl_start;
  // fall-through shift into output stage when it is free or being read
  wire ft_take = ~out_valid_reg | (~ren_n & ld_n);
  // an offset read-back owns the output register on its edge, so no word
  // may fall through then or it would be lost behind the offset byte
  wire ft_load = r_edge & ld_n & mem_has_data & ft_take & ~replay_busy
                 & ~rpl_start;
  wire ft_drain = r_edge & ~ren_n & ld_n & out_valid_reg & ~mem_has_data
                  & ~replay_busy;
  // the mode picks which read path moves the pointer
  wire rd_go = o_fallthrough_mode ? ft_load : std_rd;

  ////////////////////////////////////////////////////////////////////////
  // mode and loading method are caught while the full clear is held
  // limitation: the pins are sampled, so a full clear shorter than the
  // synchroniser latency resets the datapath but may miss the mode
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fallthrough_mode <= 1'b0;
      o_serial_method <= 1'b0;
    end else if (fclr_act) begin
      o_fallthrough_mode <= fsi;
      o_serial_method <= ld_n;
    end
  end

  // offsets: defaults at full clear, untouched by partial clear
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      empty_off_reg <= `HDCF_OFF_DEF_PAR;
      full_off_reg <= `HDCF_OFF_DEF_PAR;
      wslot_reg <= `HDCF_SLOT_E_LSB;
    end else if (fclr_act) begin
      empty_off_reg <= ld_n ? `HDCF_OFF_DEF_SER : `HDCF_OFF_DEF_PAR;
      full_off_reg <= ld_n ? `HDCF_OFF_DEF_SER : `HDCF_OFF_DEF_PAR;
      wslot_reg <= `HDCF_SLOT_E_LSB;
    end else if (par_load) begin
      case (wslot_reg)
        `HDCF_SLOT_E_LSB: empty_off_reg[7:0] <= wdata[7:0];
        `HDCF_SLOT_E_MSB: empty_off_reg[15:8] <= wdata[7:0];
        `HDCF_SLOT_F_LSB: full_off_reg[7:0] <= wdata[7:0];
        default: full_off_reg[15:8] <= wdata[7:0];
      endcase
      wslot_reg <= wslot_reg + 2'h1;
    end else if (ser_load) begin
      // one bit per write edge, full offset first from its top bit, empty offset after
      {full_off_reg, empty_off_reg} <= {full_off_reg[`HDCF_OFF_W-2:0],
                                        empty_off_reg, fsi};
    end
  end

  // read-back pointer walks the four offset bytes; partial clear spares it
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rslot_reg <= `HDCF_SLOT_E_LSB;
    end else if (fclr_act) begin
      rslot_reg <= `HDCF_SLOT_E_LSB;
    end else if (off_read) begin
      rslot_reg <= rslot_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array write has no reset: contents are meaningless until written
  always @(posedge i_core_clk) begin
    if (wr_go) begin
      mem[waddr] <= wdata;
    end
  end

  // write pointer in the write domain, advanced only on write edges
  always @(posedge i_core_clk or posedge clr_any) begin
    if (clr_any) begin
      wptr_reg <= {`HDCF_PTR_W{1'b0}};
      wgray_reg <= {`HDCF_PTR_W{1'b0}};
    end else if (wr_go) begin
      wptr_reg <= wptr_inc;
      wgray_reg <= bin2gray(wptr_inc);
    end
  end

  // read pointer side sampled into write domain on write edges only;
  // full therefore frees two write edges after the read (hazard: a
  // stopped write clock keeps full set, which is what the pin promises)
  always @(posedge i_core_clk or posedge clr_any) begin
    if (clr_any) begin
      rq1_reg <= {`HDCF_PTR_W{1'b0}};
      rq2_reg <= {`HDCF_PTR_W{1'b0}};
    end else if (w_edge) begin
      rq1_reg <= rgray_reg;
      rq2_reg <= rq1_reg;
    end
  end

  // write pointer sampled into read domain on read edges only
  always @(posedge i_core_clk or posedge clr_any) begin
    if (clr_any) begin
      wq1_reg <= {`HDCF_PTR_W{1'b0}};
      wq2_reg <= {`HDCF_PTR_W{1'b0}};
    end else if (r_edge) begin
      wq1_reg <= wgray_reg;
      wq2_reg <= wq1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read side: pointer, replay setup and output-stage state.
  // replay rewinds the pointer in one jump; the gray copy is then not a
  // single-bit step, safe only because writes are idle during setup
  always @(posedge i_core_clk or posedge clr_any) begin
    if (clr_any) begin
      rptr_reg <= {`HDCF_PTR_W{1'b0}};
      rgray_reg <= {`HDCF_PTR_W{1'b0}};
      replay_cnt_reg <= 2'h0;
      out_valid_reg <= 1'b0;
    end else if (rpl_start) begin
      rptr_reg <= {`HDCF_PTR_W{1'b0}};
      rgray_reg <= {`HDCF_PTR_W{1'b0}};
      replay_cnt_reg <= `HDCF_REPLAY_EDGES;
      out_valid_reg <= 1'b0;
    end else if (r_edge && replay_busy) begin
      replay_cnt_reg <= replay_cnt_reg - 2'h1;
    end else if (rd_go) begin
      rptr_reg <= rptr_inc;
      rgray_reg <= bin2gray(rptr_inc);
      out_valid_reg <= 1'b1;
    end else if (ft_drain) begin
      out_valid_reg <= 1'b0;
    end
  end

  // output register: array word, offset byte, or held value;
  // an offset read-back overwrites whatever word was on the outputs
  always @(posedge i_core_clk or posedge clr_any) begin
    if (clr_any) begin
      o_rd_data <= {`HDCF_DATA_W{1'b0}};
    end else if (off_read) begin
      case (rslot_reg)
        `HDCF_SLOT_E_LSB: o_rd_data <= {1'b0, empty_off_reg[7:0]};
        `HDCF_SLOT_E_MSB: o_rd_data <= {1'b0, empty_off_reg[15:8]};
        `HDCF_SLOT_F_LSB: o_rd_data <= {1'b0, full_off_reg[7:0]};
        default: o_rd_data <= {1'b0, full_off_reg[15:8]};
      endcase
    end else if (rd_go) begin
      o_rd_data <= mem[raddr];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dual-purpose flag pins: standard empty/full or fall-through
  // output-valid/input-space, both active low
  assign o_empty_flag_n = o_fallthrough_mode ? ~out_valid_reg
                          : (mem_has_data & ~replay_busy);
  assign o_full_flag_n = o_fallthrough_mode ? full : ~full;

  // the partial flags compare against a synchronised count, so they lag
  // true occupancy by up to three edges of their own side's clock
  // almost-empty moves on read edges only
  always @(posedge i_core_clk or posedge clr_any) begin
    if (clr_any) begin
      o_almost_empty_n <= 1'b0;
    end else if (r_edge) begin
      o_almost_empty_n <= (cnt_r > {1'b0, empty_off_reg});
    end
  end

  // almost-full moves on write edges only
  always @(posedge i_core_clk or posedge clr_any) begin
    if (clr_any) begin
      o_almost_full_n <= 1'b1;
    end else if (w_edge) begin
      o_almost_full_n <= (cnt_w < (`HDCF_DEPTH - {1'b0, full_off_reg}));
    end
  end

  // half-full: write edges can only pull it low, read edges only lift it
  always @(posedge i_core_clk or posedge clr_any) begin
    if (clr_any) begin
      o_half_full_n <= 1'b1;
    end else if (w_edge && (cnt_w > `HDCF_HALF)) begin
      o_half_full_n <= 1'b0;
    end else if (r_edge && (cnt_r <= `HDCF_HALF)) begin
      o_half_full_n <= 1'b1;
    end
  end

endmodule

/* verification/hdcf_far.sv */
// far-side writer and reader agents driving stoppable link clocks
`timescale 1ns/1ps
`include "hdcf_map.vh"
module hdcf_far (
  input wire logic i_core_clk,
  output logic o_wr_clk,
  output logic o_wr_en_n,
  output logic [`HDCF_DATA_W-1:0] o_wr_data,
  output logic o_rd_clk,
  output logic o_rd_en_n
);
  // both link clocks rest low and both enables idle until a transfer
  initial begin
    o_wr_clk = 1'b0;
    o_wr_en_n = 1'b1;
    o_wr_data = 9'h000;
    o_rd_clk = 1'b0;
    o_rd_en_n = 1'b1;
  end
  // one 160 ns link period: qualifiers lead the rise by 80 ns and hold to
  // the fall, then the clock rests low until the next transfer
  task automatic wr(input logic [`HDCF_DATA_W-1:0] d);
    @(posedge i_core_clk);
    #1;
    o_wr_en_n = 1'b0;
    o_wr_data = d;
    repeat (8) @(posedge i_core_clk);
    #1;
    o_wr_clk = 1'b1;
    repeat (8) @(posedge i_core_clk);
    #1;
    o_wr_clk = 1'b0;
    o_wr_en_n = 1'b1;
    o_wr_data = ~d; // released data never repeats the word
  endtask
  // a word is requested only when the caller asks for it
  task automatic rd(input logic en_n);
    @(posedge i_core_clk);
    #1;
    o_rd_en_n = en_n;
    repeat (8) @(posedge i_core_clk);
    #1;
    o_rd_clk = 1'b1;
    repeat (8) @(posedge i_core_clk);
    #1;
    o_rd_clk = 1'b0;
    o_rd_en_n = 1'b1;
  endtask
endmodule

/* verification/hdcf_chk.sv */
// assertion checker watching the buffer control ports
`timescale 1ns/1ps
`include "hdcf_map.vh"
module hdcf_chk (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_full_clear_n,
  input wire logic i_partial_clear_n,
  input wire logic i_wr_clk,
  input wire logic i_rd_clk,
  input wire logic i_rd_en_n,
  input wire logic i_offset_load_n,
  input wire logic i_fallthrough_select_serial_in,
  input wire logic [`HDCF_DATA_W-1:0] o_rd_data,
  input wire logic o_empty_flag_n,
  input wire logic o_full_flag_n,
  input wire logic o_almost_empty_n,
  input wire logic o_almost_full_n,
  input wire logic o_half_full_n,
  input wire logic o_fallthrough_mode,
  input wire logic o_serial_method
);
////////////////////////////////////////////////////////////////////////
  logic [3:0] wq_reg, rq_reg, dq_reg;
  logic wck_reg, rck_reg, clr;
  // quiet spans count from the raw pins; 15 cycles is well past the pin
  // synchroniser latency, so any later flag motion is spurious
  function automatic logic [3:0] sat(input logic [3:0] q, input logic hit);
    return hit ? 4'h0 : (q == 4'hF) ? q : q + 4'h1;
  endfunction
  assign clr = !i_full_clear_n || !i_partial_clear_n;
  // quiet counters for write clock, read clock and read requests
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wq_reg <= 4'h0;
      rq_reg <= 4'h0;
      dq_reg <= 4'h0;
      wck_reg <= 1'b0;
      rck_reg <= 1'b0;
    end else begin
      wck_reg <= i_wr_clk;
      rck_reg <= i_rd_clk;
      wq_reg <= sat(wq_reg, clr || (i_wr_clk != wck_reg));
      rq_reg <= sat(rq_reg, clr || (i_rd_clk != rck_reg));
      dq_reg <= sat(dq_reg, clr || !i_rd_en_n);
    end
  end
////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_clear_ptrs: assert property ((!i_full_clear_n) [*2] |->
    o_rd_data == 9'h000 && !o_almost_empty_n
    && o_almost_full_n && o_half_full_n) else $error("full clear flags");
  a_clear_mode: assert property ((!i_full_clear_n &&
    $stable(i_fallthrough_select_serial_in) && $stable(i_offset_load_n)) [*8]
    |-> o_fallthrough_mode == i_fallthrough_select_serial_in
    && o_serial_method == i_offset_load_n) else $error("mode not taken");
  a_clear_polar: assert property ((!i_full_clear_n) [*8] |->
    o_empty_flag_n == o_fallthrough_mode
    && o_full_flag_n == !o_fallthrough_mode) else $error("clear polarity");
  a_part_flags: assert property ((i_full_clear_n && !i_partial_clear_n) [*2]
    |-> o_rd_data == 9'h000 && !o_almost_empty_n && o_almost_full_n
    && o_half_full_n && o_empty_flag_n == o_fallthrough_mode
    && o_full_flag_n != o_fallthrough_mode) else $error("partial clear");
  a_part_keep: assert property (i_full_clear_n && !i_partial_clear_n |=>
    $stable(o_fallthrough_mode) && $stable(o_serial_method))
    else $error("partial clear changed mode or method");
  a_rd_hold: assert property (dq_reg == 4'hF && !o_fallthrough_mode |=>
    $stable(o_rd_data)) else $error("output moved without a request");
  a_wclk_idle: assert property (wq_reg == 4'hF |=>
    $stable(o_full_flag_n) && $stable(o_almost_full_n))
    else $error("write flags moved with write clock idle");
  a_rclk_idle: assert property (rq_reg == 4'hF |=>
    $stable(o_empty_flag_n) && $stable(o_almost_empty_n))
    else $error("read flags moved with read clock idle");
endmodule
////////////////////////////////////////////////////////////////////////
bind hdcf_top hdcf_chk u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_full_clear_n(i_full_clear_n), .i_partial_clear_n(i_partial_clear_n),
  .i_wr_clk(i_wr_clk), .i_rd_clk(i_rd_clk), .i_rd_en_n(i_rd_en_n),
  .i_offset_load_n(i_offset_load_n),
  .i_fallthrough_select_serial_in(i_fallthrough_select_serial_in),
  .o_rd_data(o_rd_data), .o_empty_flag_n(o_empty_flag_n),
  .o_full_flag_n(o_full_flag_n), .o_almost_empty_n(o_almost_empty_n),
  .o_almost_full_n(o_almost_full_n), .o_half_full_n(o_half_full_n),
  .o_fallthrough_mode(o_fallthrough_mode), .o_serial_method(o_serial_method));

/* verification/hdcf_tb.sv */
// self-checking bench for the dual-clock buffer control block
`timescale 1ns/1ps
`include "hdcf_map.vh"
module testbench;
  logic i_core_clk;
  logic i_rst;
  logic fc_n, pc_n, rpl_n, ld_n;
  logic fsel, sen_n;
  logic wclk, wen_n, rclk, ren_n, ef_n, ff_n, ae_n, af_n, hf_n, mode, smeth;
  logic [`HDCF_DATA_W-1:0] wdat, rdat;
  logic [6:0] flg;
  logic [8:0] words [3] = '{9'h1FF, 9'h0A5, 9'h100};
  int n_mismatch = 0;
  int tests_run = 0;
  assign flg = {ef_n, ff_n, ae_n, af_n, hf_n, mode, smeth};
  // core clock, 100 MHz
  always #5 i_core_clk = ~i_core_clk;
  hdcf_top u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_full_clear_n(fc_n), .i_partial_clear_n(pc_n), .i_wr_clk(wclk),
    .i_wr_en_n(wen_n), .i_wr_data(wdat), .i_rd_clk(rclk), .i_rd_en_n(ren_n),
    .i_replay_n(rpl_n), .i_offset_load_n(ld_n), .i_serial_en_n(sen_n),
    .i_fallthrough_select_serial_in(fsel), .o_rd_data(rdat),
    .o_empty_flag_n(ef_n), .o_full_flag_n(ff_n), .o_almost_empty_n(ae_n),
    .o_almost_full_n(af_n), .o_half_full_n(hf_n), .o_fallthrough_mode(mode),
    .o_serial_method(smeth));
  hdcf_far u_far (.i_core_clk(i_core_clk), .o_wr_clk(wclk),
    .o_wr_en_n(wen_n), .o_wr_data(wdat), .o_rd_clk(rclk), .o_rd_en_n(ren_n));
////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // pins settle a cycle ahead and clear lasts past the synchroniser window
  task automatic clr_full(input logic sel, input logic ld);
    tick(1);
    fsel = sel;
    ld_n = ld;
    tick(1);
    fc_n = 1'b0;
    tick(9);
    fc_n = 1'b1;
    tick(8);
    fsel = 1'b0;
    ld_n = 1'b1;
  endtask
  // offset read-back walks empty low, empty high, full low, full high
  task automatic offs(input logic [8:0] lo, input logic [8:0] hi);
    ld_n = 1'b0;
    for (int i = 0; i < 4; i++) begin
      u_far.rd(1'b0);
      check("offset", rdat, i[0] ? hi : lo);
    end
    ld_n = 1'b1;
  endtask
  // standard mode: flag latency, requested reads, replay, partial clear
  task automatic t_std;
    clr_full(1'b0, 1'b0);
    check("flags", flg, 7'h2C);
    check("data", rdat, 9'h000);
    for (int i = 0; i < 3; i++) u_far.wr(words[i]);
    u_far.rd(1'b1);
    check("empty", ef_n, 1'h0);
    u_far.rd(1'b1);
    check("empty", ef_n, 1'h1);
    check("data", rdat, 9'h000);
    for (int i = 0; i < 4; i++) begin
      u_far.rd(1'b0);
      check("data", rdat, words[i > 2 ? 2 : i]);
    end
    check("empty", ef_n, 1'h0);
    u_far.wr(9'h0C3);
    u_far.rd(1'b1);
    u_far.rd(1'b1);
    rpl_n = 1'b0;
    u_far.rd(1'b1);
    rpl_n = 1'b1;
    check("empty", ef_n, 1'h0);
    u_far.rd(1'b1);
    u_far.rd(1'b1);
    check("empty", ef_n, 1'h1);
    check("data", rdat, 9'h100);
    u_far.rd(1'b0);
    check("data", rdat, 9'h1FF);
    pc_n = 1'b0;
    tick(9);
    check("flags", flg, 7'h2C);
    check("data", rdat, 9'h000);
    pc_n = 1'b1;
    tick(8);
    offs(9'h07F, 9'h000);
    $display("standard mode test done");
  endtask
  // fall-through mode: first word shows by itself, last read keeps data
  task automatic t_fallthrough_mode;
    logic [31:0] ser;
    clr_full(1'b1, 1'b1);
    check("flags", flg, 7'h4F);
    u_far.wr(9'h15A);
    u_far.rd(1'b1);
    u_far.rd(1'b1);
    check("data", rdat, 9'h000);
    u_far.rd(1'b1);
    check("data", rdat, 9'h15A);
    check("valid", ef_n, 1'h0);
    u_far.rd(1'b0);
    check("valid", ef_n, 1'h1);
    check("data", rdat, 9'h15A);
    offs(9'h0FF, 9'h003);
    // serial load, first bit ends in the full offset top; the word on
    // the data bus must not reach the offsets under the serial method
    ser = 32'h12341234;
    ld_n = 1'b0;
    sen_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      fsel = ser[i];
      u_far.wr(9'h0AA);
    end
    ld_n = 1'b1;
    sen_n = 1'b1;
    fsel = 1'b0;
    offs(9'h034, 9'h012);
    $display("fall-through test done");
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    i_rst = 1'b1;
    fc_n = 1'b1;
    pc_n = 1'b1;
    rpl_n = 1'b1;
    ld_n = 1'b1;
    fsel = 1'b0;
    sen_n = 1'b1;
    repeat (12) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    t_std;
    t_fallthrough_mode;
    results;
  end
  // the sequence needs about 11 us of link traffic; allow about nine times that
  initial begin
    #100000;
    n_mismatch++;
    results;
  end
endmodule
